// ==== gx_pkg.sv ====
`default_nettype none

package gx_pkg;

  // Port width and register pointer codes
  localparam int          GX_WIDTH        = 8;
  localparam logic [1:0]  GX_REG_INPUT    = 2'h0;
  localparam logic [1:0]  GX_REG_DRIVE    = 2'h1;
  localparam logic [1:0]  GX_REG_INVERT   = 2'h2;
  localparam logic [1:0]  GX_REG_DIR      = 2'h3;

  // Reset values
  localparam logic [7:0]  GX_DRIVE_RST    = 8'hFF;
  localparam logic [7:0]  GX_INVERT_RST   = 8'h00;
  localparam logic [7:0]  GX_DIR_RST      = 8'hFF;
  localparam logic [1:0]  GX_PTR_RST      = 2'h0;

  // Bus address and byte framing
  localparam logic [4:0]  GX_ADDR_FIXED   = 5'h1C;
  localparam logic [3:0]  GX_ACK_BIT      = 4'h8;
  localparam int          GX_RW_BIT       = 0;

  // Cycles after reset during which the change reference follows the pins
  localparam logic [1:0]  GX_INIT_DONE    = 2'h3;

  // Serial bus protocol states
  typedef enum logic [2:0] {
    GX_IDLE,
    GX_ADDR,
    GX_CMD,
    GX_WRITE,
    GX_READ
  } gx_bus_state_e;

  // Software-writable registers
  typedef struct packed {
    logic [GX_WIDTH-1:0] drive;
    logic [GX_WIDTH-1:0] invert;
    logic [GX_WIDTH-1:0] dir;
  } gx_regs_s;

endpackage : gx_pkg

`default_nettype wire

// ==== gx_sync2.sv ====
`timescale 1ns/1ps
`default_nettype none

module gx_sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             arst_n,
  // Asynchronous levels in, synchronised levels out
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] meta_q;

  // Elaboration check on the width
  if (WIDTH < 1) begin : g_width_bad
    $error("gx_sync2: WIDTH must be at least 1");
  end

  // Two flops; the first is read only by the second
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      meta_q  <= '0;
      syncOut <= '0;
    end else begin
      meta_q  <= asyncIn;
      syncOut <= meta_q;
    end
  end

endmodule : gx_sync2

`default_nettype wire

// ==== gx_io_expander.sv ====
`timescale 1ns/1ps
`default_nettype none

module gx_io_expander
  import gx_pkg::*;
(
  // System clock and reset (power-on and reset pin combined)
  input  wire logic                clock,
  input  wire logic                arst_n,
  // Serial bus: clock in, open-drain data
  input  wire logic                sclClk,
  input  wire logic                sdaIn,
  output logic                     sdaOut,
  output logic                     sdaOe,
  // Address select straps
  input  wire logic                addrSelectLow,
  input  wire logic                addrSelectHigh,
  // Port pins
  input  wire logic [GX_WIDTH-1:0] pinIn,
  output logic      [GX_WIDTH-1:0] pinOut,
  output logic      [GX_WIDTH-1:0] pinOe,
  output logic      [GX_WIDTH-1:0] highSideDriver,
  output logic      [GX_WIDTH-1:0] lowSideDriver,
  // Open-drain interrupt
  output logic                     intOut,
  output logic                     intOe
);

  localparam int SYNC_W = GX_WIDTH + 5;

  // Link domain state
  logic                linkBit_q;
  logic                linkTgl_q;

  // Synchronised pins
  logic [SYNC_W-1:0]   syncIn;
  logic [SYNC_W-1:0]   syncOut;
  logic                tglS;
  logic                sclS;
  logic                sdaS;
  logic                aHighS;
  logic                aLowS;
  logic [GX_WIDTH-1:0] pinS;

  // System domain state
  logic                tglPrev_q;
  logic                sclPrev_q;
  logic                sdaPrev_q;
  gx_bus_state_e       state_q;
  gx_bus_state_e       state_d;
  logic [3:0]          bitCnt_q;
  logic [3:0]          bitCnt_d;
  logic [7:0]          shift_q;
  logic [7:0]          shift_d;
  logic [1:0]          ptr_q;
  logic [1:0]          ptr_d;
  gx_regs_s            regs_q;
  gx_regs_s            regs_d;
  logic [7:0]          tx_q;
  logic [7:0]          tx_d;
  logic                sdaLow_q;
  logic                sdaLow_d;
  logic [GX_WIDTH-1:0] snap_q;
  logic [GX_WIDTH-1:0] snap_d;
  logic                intPend_q;
  logic [1:0]          initCnt_q;

  // Decoded events and selections
  logic                bitEvt;
  logic                sclFall;
  logic                startSeen;
  logic                stopSeen;
  logic                ackSlot;
  logic                active;
  logic                dataBit;
  logic                ackEvt;
  logic                addrHit;
  logic                loadTx;
  logic                loadInput;
  logic                writeEvt;
  logic                sdaDrive;
  logic [GX_WIDTH-1:0] readView;
  logic [GX_WIDTH-1:0] regSel;
  logic [GX_WIDTH-1:0] changed;

  // Link domain: capture data on each rising serial clock
  always_ff @(posedge sclClk or negedge arst_n) begin
    if (!arst_n) begin
      linkBit_q <= 1'b0;
      linkTgl_q <= 1'b0;
    end else begin
      linkBit_q <= sdaIn;
      linkTgl_q <= ~linkTgl_q;
    end
  end

  // Crossing: toggle and pins pass two flops; bit is stable per toggle
  assign syncIn = {linkTgl_q, sclClk, sdaIn, addrSelectHigh,
                   addrSelectLow, pinIn};

  gx_sync2 #(
    .WIDTH   (SYNC_W)
  ) uSync (
    .clock   (clock),
    .arst_n  (arst_n),
    .asyncIn (syncIn),
    .syncOut (syncOut)
  );

  assign tglS   = syncOut[GX_WIDTH+4];
  assign sclS   = syncOut[GX_WIDTH+3];
  assign sdaS   = syncOut[GX_WIDTH+2];
  assign aHighS = syncOut[GX_WIDTH+1];
  assign aLowS  = syncOut[GX_WIDTH];
  assign pinS   = syncOut[GX_WIDTH-1:0];

  // Bus condition decode
  assign bitEvt    = tglS ^ tglPrev_q;
  assign sclFall   = sclPrev_q & ~sclS;
  assign startSeen = sclS & sclPrev_q & sdaPrev_q & ~sdaS;
  assign stopSeen  = sclS & sclPrev_q & ~sdaPrev_q & sdaS;
  assign ackSlot   = (bitCnt_q == GX_ACK_BIT);
  assign active    = (state_q != GX_IDLE);
  assign dataBit   = bitEvt & active & ~ackSlot;
  assign ackEvt    = bitEvt & active & ackSlot;
  assign addrHit   = (shift_q[7:1] ==
                      {GX_ADDR_FIXED, aHighS, aLowS});

  // Register view and read selection
  assign readView = pinS ^ regs_q.invert;
  assign regSel   = (ptr_q == GX_REG_INPUT)  ? readView :
                    (ptr_q == GX_REG_DRIVE)  ? regs_q.drive :
                    (ptr_q == GX_REG_INVERT) ? regs_q.invert :
                                               regs_q.dir;

  // Byte load for transmit: after address read-hit or master acknowledge
  assign loadTx    = ackEvt &
                     (((state_q == GX_ADDR) & addrHit &
                       shift_q[GX_RW_BIT]) |
                      ((state_q == GX_READ) & ~linkBit_q));
  assign loadInput = loadTx & (ptr_q == GX_REG_INPUT);
  assign writeEvt  = ackEvt & (state_q == GX_WRITE);

  // Data line pull-low to present after the next falling serial clock
  assign sdaDrive = ackSlot ?
                    (((state_q == GX_ADDR) & addrHit) |
                     (state_q == GX_CMD) | (state_q == GX_WRITE)) :
                    ((state_q == GX_READ) & ~tx_q[7]);

  // Protocol state, pointer and register updates
  always_comb begin
    state_d  = state_q;
    bitCnt_d = bitCnt_q;
    shift_d  = shift_q;
    ptr_d    = ptr_q;
    regs_d   = regs_q;
    if (stopSeen) begin
      state_d = GX_IDLE;
    end else if (startSeen) begin
      state_d  = GX_ADDR;
      bitCnt_d = 4'h0;
    end else if (dataBit) begin
      shift_d  = {shift_q[6:0], linkBit_q};
      bitCnt_d = bitCnt_q + 4'h1;
    end else if (ackEvt) begin
      bitCnt_d = 4'h0;
      case (state_q)
        GX_ADDR: begin
          if (!addrHit) state_d = GX_IDLE;
          else if (shift_q[GX_RW_BIT]) state_d = GX_READ;
          else state_d = GX_CMD;
        end
        GX_CMD: begin
          ptr_d   = shift_q[1:0];
          state_d = GX_WRITE;
        end
        GX_WRITE: begin
          case (ptr_q)
            GX_REG_DRIVE:  regs_d.drive  = shift_q;
            GX_REG_INVERT: regs_d.invert = shift_q;
            GX_REG_DIR:    regs_d.dir    = shift_q;
            default:       regs_d        = regs_q;
          endcase
        end
        GX_READ: begin
          if (linkBit_q) state_d = GX_IDLE;
        end
        default: state_d = GX_IDLE;
      endcase
    end
  end

  // Transmit byte, data line drive and change reference
  assign tx_d     = loadTx ? regSel :
                    (dataBit & (state_q == GX_READ)) ?
                    {tx_q[6:0], 1'b0} : tx_q;
  assign sdaLow_d = (startSeen | stopSeen) ? 1'b0 :
                    sclFall ? sdaDrive : sdaLow_q;
  assign snap_d   = ((initCnt_q != GX_INIT_DONE) | loadInput) ?
                    pinS : snap_q;
  assign changed  = (pinS ^ snap_q) & regs_q.dir;

  // Bus edge history
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tglPrev_q <= 1'b0;
      sclPrev_q <= 1'b0;
      sdaPrev_q <= 1'b0;
    end else begin
      tglPrev_q <= tglS;
      sclPrev_q <= sclS;
      sdaPrev_q <= sdaS;
    end
  end

  // Protocol and register state; reset holds defaults
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_q  <= GX_IDLE;
      bitCnt_q <= 4'h0;
      shift_q  <= 8'h00;
      ptr_q    <= GX_PTR_RST;
      regs_q   <= '{GX_DRIVE_RST, GX_INVERT_RST, GX_DIR_RST};
    end else begin
      state_q  <= state_d;
      bitCnt_q <= bitCnt_d;
      shift_q  <= shift_d;
      ptr_q    <= ptr_d;
      regs_q   <= regs_d;
    end
  end

  // Transmit, drive and interrupt state
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tx_q      <= 8'h00;
      sdaLow_q  <= 1'b0;
      snap_q    <= '0;
      intPend_q <= 1'b0;
      initCnt_q <= 2'h0;
    end else begin
      tx_q      <= tx_d;
      sdaLow_q  <= sdaLow_d;
      snap_q    <= snap_d;
      // No interrupt while the reference still follows the pins
      intPend_q <= (initCnt_q == GX_INIT_DONE) & (|changed);
      if (initCnt_q != GX_INIT_DONE) initCnt_q <= initCnt_q + 2'h1;
    end
  end

  // Pin drivers: both off for inputs, exactly one on for outputs
  assign pinOut         = regs_q.drive;
  assign pinOe          = ~regs_q.dir;
  assign highSideDriver = pinOe & regs_q.drive;
  assign lowSideDriver  = pinOe & ~regs_q.drive;

  // Open-drain outputs only ever pull low
  assign sdaOut = 1'b0;
  assign sdaOe  = sdaLow_q;
  assign intOut = 1'b0;
  assign intOe  = intPend_q;

  // Checks on the system clock
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  sequence inputRead_s;
    loadInput ##1 $stable(pinS);
  endsequence

  sequence cmdWrite_s;
    writeEvt && (ptr_q == GX_REG_DRIVE);
  endsequence

  input_view_a: assert property (
    loadInput |=> tx_q == $past(pinS ^ regs_q.invert))
    else $error("input byte not pin level xor invert");

  input_ro_a: assert property (
    (writeEvt && ptr_q == GX_REG_INPUT) |=> regs_q == $past(regs_q))
    else $error("write to input register changed state");

  latch_read_a: assert property (
    (loadTx && ptr_q == GX_REG_DRIVE) |=> tx_q == $past(regs_q.drive))
    else $error("output register read not latch value");

  drive_pair_a: assert property (
    ((highSideDriver ^ lowSideDriver) == ~regs_q.dir) &&
    ((highSideDriver & ~regs_q.drive) == '0))
    else $error("pin driver pair inconsistent with registers");

  reset_dir_a: assert property (
    (initCnt_q == 2'h0) |-> (regs_q.dir == GX_DIR_RST) &&
    (regs_q.drive == GX_DRIVE_RST) && (state_q == GX_IDLE))
    else $error("defaults not held after reset");

  int_raise_a: assert property (
    (initCnt_q == GX_INIT_DONE) &&
    (|((pinS ^ snap_q) & regs_q.dir)) |=> intOe && !intOut)
    else $error("input change did not raise interrupt");

  int_clear_a: assert property (
    inputRead_s |=> !intOe)
    else $error("interrupt not cleared by input read");

  int_return_a: assert property (
    (((pinS ^ snap_q) & regs_q.dir) == '0) |=> !intOe)
    else $error("interrupt held after input returned");

  no_autoinc_a: assert property (
    (state_q == GX_READ) && !startSeen |=> $stable(ptr_q))
    else $error("register pointer moved during read");

  cmd_ptr_a: assert property (
    (ackEvt && state_q == GX_CMD) |=> ptr_q == $past(shift_q[1:0]))
    else $error("command byte not taken as pointer");

  write_commit_a: assert property (
    cmdWrite_s |=> regs_q.drive == $past(shift_q)
                   ##1 pinOut == $past(shift_q, 2))
    else $error("acknowledged byte not applied to latch");

  stop_keep_a: assert property (
    stopSeen |=> (state_q == GX_IDLE) && $stable(regs_q))
    else $error("stop lost acknowledged data");

  addr_miss_a: assert property (
    (sclFall && ackSlot && state_q == GX_ADDR && !addrHit) |=> !sdaOe)
    else $error("device acknowledged foreign address");

endmodule : gx_io_expander

`default_nettype wire

// ==== gx_bus_master.sv ====
`timescale 1ns/1ps
`default_nettype none

module gx_bus_master (
  // System clock paces the bit timing
  input  wire logic clock,
  // Bus lines: clock and open-drain data pull
  output logic      sclClk,
  output logic      sdaLow,
  input  wire logic sdaLine
);
  // Bus idle: clock stands high, data released
  initial begin
    sclClk = 1'b1;
    sdaLow = 1'b0;
  end

  // Half bit period of ten system clocks
  task automatic half;
    repeat (10) @(posedge clock);
  endtask : half

  // One bit: data moves after the hold time, sampled at end of high
  task automatic bitIo(input logic b, output logic r);
    repeat (5) @(posedge clock);
    sdaLow <= ~b;
    half();
    sclClk <= 1'b1;
    half();
    r = sdaLine;
    sclClk <= 1'b0;
  endtask : bitIo

  // Start or repeated start, leaves clock low
  task automatic startC;
    repeat (5) @(posedge clock);
    sdaLow <= 1'b0;
    half();
    sclClk <= 1'b1;
    half();
    sdaLow <= 1'b1;
    half();
    sclClk <= 1'b0;
  endtask : startC

  // Stop may come at any bit boundary
  task automatic stopC;
    repeat (5) @(posedge clock);
    sdaLow <= 1'b1;
    half();
    sclClk <= 1'b1;
    half();
    sdaLow <= 1'b0;
    half();
  endtask : stopC

  // Byte out MSB first, then the acknowledge slot
  task automatic byteOut(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitIo(b[i], r);
    bitIo(1'b1, r);
    ack = ~r;
  endtask : byteOut

  // Byte in MSB first, then our acknowledge or not
  task automatic byteIn(output logic [7:0] b, input logic ackIt);
    logic r;
    for (int i = 7; i >= 0; i--) bitIo(1'b1, b[i]);
    bitIo(~ackIt, r);
  endtask : byteIn
endmodule : gx_bus_master

`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import gx_pkg::*;
;
  typedef struct {logic w; logic [1:0] p; logic [7:0] d, r;} gx_row_s;

  logic            clock, arst_n, selLow, selHigh, ack;
  logic      [7:0] ext, d0, d1;
  logic      [7:0] m [4];
  wire logic       sclClk, sdaLow, sdaOut, sdaOe, intOut, intOe;
  wire logic       sdaLine, intLine;
  wire logic [7:0] pinIn, pinOut, pinOe, hiDrv, loDrv;
  int              n_errors, comparisons;
  gx_row_s         rows [7] = '{
    '{1'b0, 2'h1, 8'h00, 8'hFF}, '{1'b0, 2'h2, 8'h00, 8'h00},
    '{1'b0, 2'h3, 8'h00, 8'hFF}, '{1'b1, 2'h1, 8'h55, 8'h55},
    '{1'b1, 2'h2, 8'h0F, 8'h0F}, '{1'b1, 2'h3, 8'hF0, 8'hF0},
    '{1'b1, 2'h0, 8'hAA, 8'h3A}};

  // Wire levels: pull-ups on data and interrupt, pins from both sides
  assign sdaLine = ~(sdaLow | (sdaOe & ~sdaOut));
  assign intLine = intOe ? intOut : 1'b1;
  assign pinIn   = (pinOe & pinOut) | (~pinOe & ext);

  gx_io_expander DUT (.clock(clock), .arst_n(arst_n), .sclClk(sclClk),
    .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .addrSelectLow(selLow), .addrSelectHigh(selHigh), .pinIn(pinIn),
    .pinOut(pinOut), .pinOe(pinOe), .highSideDriver(hiDrv),
    .lowSideDriver(loDrv), .intOut(intOut), .intOe(intOe));
  gx_bus_master M (.clock(clock), .sclClk(sclClk), .sdaLow(sdaLow),
    .sdaLine(sdaLine));

  // System clock
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // Compare and count
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic conclude;
    $display("checks %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude

  // Address plus command byte, frame left open
  task automatic setPtr(input logic [1:0] p);
    M.startC();
    M.byteOut({GX_ADDR_FIXED, selHigh, selLow, 1'b0}, ack);
    chk("addr ack", 8'(ack), 8'h01);
    M.byteOut({6'h00, p}, ack);
    chk("cmd ack", 8'(ack), 8'h01);
  endtask : setPtr

  task automatic wr(input logic [1:0] p, input logic [7:0] d);
    setPtr(p);
    M.byteOut(d, ack);
    chk("data ack", 8'(ack), 8'h01);
    M.stopC();
  endtask : wr

  // Two bytes read with no new command between them
  task automatic rd(input logic [1:0] p, output logic [7:0] a, b);
    setPtr(p);
    M.startC();
    M.byteOut({GX_ADDR_FIXED, selHigh, selLow, 1'b1}, ack);
    chk("read ack", 8'(ack), 8'h01);
    M.byteIn(a, 1'b1);
    M.byteIn(b, 1'b0);
    M.stopC();
  endtask : rd

  task automatic waitClk(input int n);
    repeat (n) @(posedge clock);
  endtask : waitClk

  // Hang guard
  initial begin
    #2000000;
    n_errors++;
    conclude();
  end

  // Main sequence
  initial begin
    arst_n = 1'b0;
    selLow = 1'b1;
    selHigh = 1'b0;
    ext = 8'h3C;
    m = '{8'h00, 8'hFF, 8'h00, 8'hFF};
    waitClk(2);
    chk("oe in reset", pinOe, 8'h00);
    chk("int in reset", 8'(intLine), 8'h01);
    arst_n <= 1'b1;
    waitClk(4);
    chk("int start", 8'(intOe), 8'h00);
    waitClk(1);
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].p, rows[i].d);
      if (rows[i].w && rows[i].p != 2'h0) m[rows[i].p] = rows[i].d;
      rd(rows[i].p, d0, d1);
      chk("read", d0, rows[i].r);
      chk("reread", d1, rows[i].r);
      chk("oe", pinOe, ~m[3]);
      chk("high", hiDrv, ~m[3] & m[1]);
      chk("low", loDrv, ~m[3] & ~m[1]);
      chk("out", pinOut, m[1]);
    end
    $display("test register table done");
    ext <= 8'h2C;
    waitClk(6);
    chk("int set", 8'(intOe), 8'h01);
    chk("int line", 8'(intLine), 8'h00);
    ext <= 8'h3C;
    waitClk(6);
    chk("int return", 8'(intLine), 8'h01);
    ext <= 8'h2C;
    waitClk(6);
    chk("int again", 8'(intOe), 8'h01);
    rd(2'h0, d0, d1);
    chk("input", d0, 8'h2A);
    chk("int read", 8'(intOe), 8'h00);
    wr(2'h3, 8'hFF);
    waitClk(6);
    chk("int switch", 8'(intOe), 8'h01);
    rd(2'h0, d0, d1);
    chk("input all", d0, 8'h23);
    $display("test interrupt done");
    M.startC();
    M.byteOut({GX_ADDR_FIXED, ~selHigh, selLow, 1'b0}, ack);
    M.stopC();
    chk("foreign ack", 8'(ack), 8'h00);
    setPtr(2'h1);
    M.byteOut(8'h33, ack);
    repeat (4) M.bitIo(1'b0, ack);
    M.stopC();
    waitClk(6);
    chk("part byte", pinOut, 8'h33);
    $display("test framing done");
    ext <= 8'h00;
    waitClk(6);
    arst_n <= 1'b0;
    waitClk(2);
    chk("oe reset", pinOe, 8'h00);
    chk("out reset", pinOut, 8'hFF);
    chk("int reset", 8'(intOe), 8'h00);
    arst_n <= 1'b1;
    waitClk(5);
    rd(2'h3, d0, d1);
    chk("dir reset", d0, 8'hFF);
    rd(2'h2, d0, d1);
    chk("inv reset", d0, 8'h00);
    chk("int quiet", 8'(intOe), 8'h00);
    $display("test reset done");
    conclude();
  end
endmodule : tb_top

`default_nettype wire
